// [pxb_crossbar.sv]
// Port crossbar: pin configuration registers, priority pin assignment,
// peripheral routing and pad drivers. Assumes an AXI4-Lite master on the
// same clock and pad inputs that are asynchronous to it.
//
// Behaviour
// - Input-mode bit one means digital input
// - Analog pin: no pullup, driver or receiver
// - Input-mode bits reset to digital
// - Output-mode bit picks open-drain or push-pull
// - Serial bus data and clock always open-drain
// - Pullup on open-drain pins unless disabled
// - Pullup disable ignores push-pull pins
// - No pullup while pin drives low
// - Enable bit activates peripheral routing
// - Disabled crossbar: plain input pins only
// - Output drivers off while crossbar disabled
// - Lowest free pin per function, priority order
// - Skipped pins count as already assigned
// - Serial transmit and receive fixed pins
// - Paired pins together; free pins stay general
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module pxb_crossbar
  import pxb_pkg::*;
(
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_b_i,
  // Register bus
  input  wire pxb_axi_req_t axi_req_i,
  output pxb_axi_rsp_t      axi_rsp_o,
  // Peripheral side
  input  wire pxb_periph_t  periph_i,
  input  wire logic         spi_four_wire_i,
  output logic [NFUNC-1:0]  periph_in_o,
  // Pad side
  input  wire logic [NPINS-1:0] pad_in_i,
  output logic [NPINS-1:0]  pad_out_o,
  output logic [NPINS-1:0]  pad_oe_o,
  output logic [NPINS-1:0]  pad_pullup_o
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic pxb_map_t route_map(input logic [NPINS-1:0] skip,
                                         input logic [NFUNC-1:0] en);
    pxb_map_t         m;
    logic [NPINS-1:0] taken;
    logic             found;
    m     = {NPINS{FN_NONE}};
    taken = skip;
    if (en[FN_TX]) begin
      m[TX_PIN]     = FN_TX;
      m[RX_PIN]     = FN_RX;
      taken[TX_PIN] = 1'b1;
      taken[RX_PIN] = 1'b1;
    end
    for (int f = int'(FN_SCK); f < NFUNC; f++) begin
      found = 1'b0;
      for (int p = 0; p < NPINS; p++) begin
        if (en[f] && !found && !taken[p]) begin
          m[p]     = 5'(f);
          taken[p] = 1'b1;
          found    = 1'b1;
        end
      end
    end
    return m;
  endfunction

  // ----------------------------------------------------------------------
  // Registers and bus state
  // ----------------------------------------------------------------------
  logic [NPINS-1:0]  in_mode_r, in_mode_nxt;
  logic [NPINS-1:0]  out_mode_r, out_mode_nxt;
  logic [NPINS-1:0]  skip_r, skip_nxt;
  logic [NPINS-1:0]  latch_r, latch_nxt;
  logic [7:0]        rsel0_r, rsel0_nxt;
  logic [7:0]        rsel1_r, rsel1_nxt;
  logic              aw_hold_r, aw_hold_nxt;
  logic              w_hold_r, w_hold_nxt;
  logic [ADDR_W-1:0] waddr_r, waddr_nxt;
  logic [31:0]       wdata_r, wdata_nxt;
  logic [3:0]        wstrb_r, wstrb_nxt;
  logic              bvalid_r, bvalid_nxt;
  logic [1:0]        bresp_r, bresp_nxt;
  logic              rvalid_r, rvalid_nxt;
  logic [31:0]       rdata_r, rdata_nxt;
  logic [1:0]        rresp_r, rresp_nxt;
  logic [NPINS-1:0]  pad_meta_r;
  logic [NPINS-1:0]  pad_sync_r;
  logic [NFUNC-1:0]  periph_in_r, periph_in_nxt;

  logic              aw_rdy;
  logic              w_rdy;
  logic              ar_rdy;
  logic              do_write;
  logic [31:0]       wr_val;

  always_comb begin
    aw_rdy   = ~aw_hold_r & ~bvalid_r;
    w_rdy    = ~w_hold_r & ~bvalid_r;
    ar_rdy   = ~rvalid_r;
    do_write = aw_hold_r & w_hold_r & ~bvalid_r;
  end

  // ----------------------------------------------------------------------
  // Register write path
  // ----------------------------------------------------------------------
  always_comb begin
    in_mode_nxt  = in_mode_r;
    out_mode_nxt = out_mode_r;
    skip_nxt     = skip_r;
    latch_nxt    = latch_r;
    rsel0_nxt    = rsel0_r;
    rsel1_nxt    = rsel1_r;
    aw_hold_nxt  = aw_hold_r | (axi_req_i.awvalid & aw_rdy);
    w_hold_nxt   = w_hold_r | (axi_req_i.wvalid & w_rdy);
    waddr_nxt    = (axi_req_i.awvalid & aw_rdy) ? axi_req_i.awaddr : waddr_r;
    wdata_nxt    = (axi_req_i.wvalid & w_rdy) ? axi_req_i.wdata : wdata_r;
    wstrb_nxt    = (axi_req_i.wvalid & w_rdy) ? axi_req_i.wstrb : wstrb_r;
    bvalid_nxt   = bvalid_r & ~axi_req_i.bready;
    bresp_nxt    = bresp_r;
    wr_val       = 32'h00000000;
    if (do_write) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = RESP_OKAY;
      if (waddr_r == OFS_IN_MODE) begin
        wr_val      = merge_bytes({8'h00, in_mode_r}, wdata_r, wstrb_r);
        in_mode_nxt = wr_val[NPINS-1:0];
      end else if (waddr_r == OFS_OUT_MODE) begin
        wr_val       = merge_bytes({8'h00, out_mode_r}, wdata_r, wstrb_r);
        out_mode_nxt = wr_val[NPINS-1:0];
      end else if (waddr_r == OFS_SKIP) begin
        wr_val   = merge_bytes({8'h00, skip_r}, wdata_r, wstrb_r);
        skip_nxt = wr_val[NPINS-1:0];
      end else if (waddr_r == OFS_RSEL0) begin
        wr_val    = merge_bytes({24'h000000, rsel0_r}, wdata_r, wstrb_r);
        rsel0_nxt = wr_val[7:0] & RSEL0_MASK;
      end else if (waddr_r == OFS_RSEL1) begin
        wr_val    = merge_bytes({24'h000000, rsel1_r}, wdata_r, wstrb_r);
        rsel1_nxt = wr_val[7:0] & RSEL1_MASK;
      end else if (waddr_r == OFS_LATCH) begin
        wr_val    = merge_bytes({8'h00, latch_r}, wdata_r, wstrb_r);
        latch_nxt = wr_val[NPINS-1:0];
      end else if (waddr_r != OFS_PIN_STATE) begin
        bresp_nxt = RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------------
  logic [NPINS-1:0] pin_rx;

  always_comb begin
    pin_rx = pad_sync_r & in_mode_r;
  end

  always_comb begin
    rvalid_nxt = rvalid_r & ~axi_req_i.rready;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (axi_req_i.arvalid && ar_rdy) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      if (axi_req_i.araddr == OFS_IN_MODE) begin
        rdata_nxt = {8'h00, in_mode_r};
      end else if (axi_req_i.araddr == OFS_OUT_MODE) begin
        rdata_nxt = {8'h00, out_mode_r};
      end else if (axi_req_i.araddr == OFS_SKIP) begin
        rdata_nxt = {8'h00, skip_r};
      end else if (axi_req_i.araddr == OFS_RSEL0) begin
        rdata_nxt = {24'h000000, rsel0_r};
      end else if (axi_req_i.araddr == OFS_RSEL1) begin
        rdata_nxt = {24'h000000, rsel1_r};
      end else if (axi_req_i.araddr == OFS_LATCH) begin
        rdata_nxt = {8'h00, latch_r};
      end else if (axi_req_i.araddr == OFS_PIN_STATE) begin
        rdata_nxt = {8'h00, pin_rx};
      end else begin
        rdata_nxt = 32'h00000000;
        rresp_nxt = RESP_SLVERR;
      end
    end
  end

  always_comb begin
    axi_rsp_o.awready = aw_rdy;
    axi_rsp_o.wready  = w_rdy;
    axi_rsp_o.bvalid  = bvalid_r;
    axi_rsp_o.bresp   = bresp_r;
    axi_rsp_o.arready = ar_rdy;
    axi_rsp_o.rvalid  = rvalid_r;
    axi_rsp_o.rdata   = rdata_r;
    axi_rsp_o.rresp   = rresp_r;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      in_mode_r  <= IN_MODE_RST;
      out_mode_r <= OUT_MODE_RST;
      skip_r     <= SKIP_RST;
      latch_r    <= LATCH_RST;
      rsel0_r    <= RSEL0_RST;
      rsel1_r    <= RSEL1_RST;
      aw_hold_r  <= 1'b0;
      w_hold_r   <= 1'b0;
      waddr_r    <= '0;
      wdata_r    <= 32'h00000000;
      wstrb_r    <= 4'h0;
      bvalid_r   <= 1'b0;
      bresp_r    <= RESP_OKAY;
      rvalid_r   <= 1'b0;
      rdata_r    <= 32'h00000000;
      rresp_r    <= RESP_OKAY;
    end else begin
      in_mode_r  <= in_mode_nxt;
      out_mode_r <= out_mode_nxt;
      skip_r     <= skip_nxt;
      latch_r    <= latch_nxt;
      rsel0_r    <= rsel0_nxt;
      rsel1_r    <= rsel1_nxt;
      aw_hold_r  <= aw_hold_nxt;
      w_hold_r   <= w_hold_nxt;
      waddr_r    <= waddr_nxt;
      wdata_r    <= wdata_nxt;
      wstrb_r    <= wstrb_nxt;
      bvalid_r   <= bvalid_nxt;
      bresp_r    <= bresp_nxt;
      rvalid_r   <= rvalid_nxt;
      rdata_r    <= rdata_nxt;
      rresp_r    <= rresp_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Priority assignment and routing
  // ----------------------------------------------------------------------
  logic             xbar_en;
  logic             wpu_dis;
  logic [1:0]       pca_cnt;
  logic [NFUNC-1:0] fn_en;
  pxb_map_t         pin_map;
  logic [NPINS-1:0] pin_val;
  logic [NPINS-1:0] pin_drv;
  logic [NPINS-1:0] od_force;

  always_comb begin
    xbar_en       = rsel1_r[R1_XBAR];
    wpu_dis       = rsel1_r[R1_WPUD];
    pca_cnt       = rsel1_r[R1_PCA_LO +: 2];
    fn_en         = '0;
    fn_en[FN_TX]  = rsel0_r[R0_UART];
    fn_en[FN_RX]  = rsel0_r[R0_UART];
    fn_en[FN_SCK] = rsel0_r[R0_SPI];
    fn_en[FN_MISO] = rsel0_r[R0_SPI];
    fn_en[FN_MOSI] = rsel0_r[R0_SPI];
    fn_en[FN_NSS] = rsel0_r[R0_SPI] & spi_four_wire_i;
    fn_en[FN_SDA] = rsel0_r[R0_SMB];
    fn_en[FN_SCL] = rsel0_r[R0_SMB];
    fn_en[FN_CMP] = rsel0_r[R0_CMP];
    fn_en[FN_CMPA] = rsel0_r[R0_CMPA];
    fn_en[FN_SYSC] = rsel0_r[R0_SYSCK];
    fn_en[FN_CEX0] = (pca_cnt != 2'h0);
    fn_en[FN_CEX1] = (pca_cnt[1] == 1'b1);
    fn_en[FN_CEX2] = (pca_cnt == 2'h3);
    fn_en[FN_CNT]  = rsel1_r[R1_CNTIN];
    fn_en[FN_TMR0] = rsel1_r[R1_TMR0];
    fn_en[FN_TMR1] = rsel1_r[R1_TMR1];
    pin_map        = route_map(skip_r, fn_en);
  end

  always_comb begin
    periph_in_nxt = '1;
    for (int p = 0; p < NPINS; p++) begin
      if (xbar_en && pin_map[p] != FN_NONE) begin
        pin_val[p]                 = periph_i.val[pin_map[p]];
        pin_drv[p]                 = periph_i.drv[pin_map[p]];
        periph_in_nxt[pin_map[p]]  = pin_rx[p];
      end else begin
        pin_val[p] = latch_r[p];
        pin_drv[p] = 1'b1;
      end
      od_force[p] = xbar_en & ((pin_map[p] == FN_SDA) | (pin_map[p] == FN_SCL));
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      pad_meta_r  <= '0;
      pad_sync_r  <= '0;
      periph_in_r <= '1;
    end else begin
      pad_meta_r  <= pad_in_i;
      pad_sync_r  <= pad_meta_r;
      periph_in_r <= periph_in_nxt;
    end
  end

  assign periph_in_o = periph_in_r;

  // ----------------------------------------------------------------------
  // Pad drivers
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < NPINS; g++) begin : g_pin
    pxb_pin_cell u_cell (
      .sys_clk_i    (sys_clk_i),
      .rst_b_i      (rst_b_i),
      .digital_i    (in_mode_r[g]),
      .push_pull_i  (out_mode_r[g]),
      .force_od_i   (od_force[g]),
      .xbar_en_i    (xbar_en),
      .wpu_dis_i    (wpu_dis),
      .val_i        (pin_val[g]),
      .drv_i        (pin_drv[g]),
      .pad_out_o    (pad_out_o[g]),
      .pad_oe_o     (pad_oe_o[g]),
      .pad_pullup_o (pad_pullup_o[g])
    );
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_state_read;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (axi_req_i.arvalid && ar_rdy && axi_req_i.araddr == OFS_PIN_STATE)
      |=> rdata_r[NPINS-1:0] == ($past(pad_sync_r) & $past(in_mode_r));
  endproperty
  a_state_read: assert property (p_state_read) else $error("pin state read wrong");

  property p_analog_off;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    1'b1 |=> ((pad_oe_o | pad_pullup_o) & ~$past(in_mode_r)) == '0;
  endproperty
  a_analog_off: assert property (p_analog_off) else $error("analog pin active");

  property p_reset_digital;
    @(posedge sys_clk_i) $rose(rst_b_i) |-> in_mode_r == IN_MODE_RST;
  endproperty
  a_reset_digital: assert property (p_reset_digital) else $error("mode reset wrong");

  property p_push_pull;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (xbar_en && in_mode_r[7] && out_mode_r[7] && pin_map[7] == FN_NONE)
      |=> pad_oe_o[7] && pad_out_o[7] == $past(latch_r[7]);
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push-pull drive wrong");

  property p_bus_od;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    1'b1 |=> (pad_out_o & pad_oe_o & $past(od_force)) == '0;
  endproperty
  a_bus_od: assert property (p_bus_od) else $error("bus pin drove high");

  property p_pullup_on;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (!wpu_dis && in_mode_r[0] && !out_mode_r[0] && !xbar_en) |=> pad_pullup_o[0];
  endproperty
  a_pullup_on: assert property (p_pullup_on) else $error("pullup missing");

  property p_pp_no_pullup;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    1'b1 |=> (pad_pullup_o & $past(out_mode_r) & ~$past(od_force)) == '0;
  endproperty
  a_pp_no_pullup: assert property (p_pp_no_pullup) else $error("pullup on push-pull");

  property p_low_no_pullup;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (pad_pullup_o & pad_oe_o & ~pad_out_o) == '0;
  endproperty
  a_low_no_pullup: assert property (p_low_no_pullup) else $error("pullup while low");

  property p_off_no_drive;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    !xbar_en |=> pad_oe_o == '0 && periph_in_r == '1;
  endproperty
  a_off_no_drive: assert property (p_off_no_drive) else $error("drive while disabled");

  property p_route_tx;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (xbar_en && fn_en[FN_TX] && in_mode_r[TX_PIN] && out_mode_r[TX_PIN])
      |=> pad_oe_o[TX_PIN] == $past(periph_i.drv[FN_TX]);
  endproperty
  a_route_tx: assert property (p_route_tx) else $error("routing not active");

  property p_first_free;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (skip_r == '0 && !fn_en[FN_TX] && fn_en[FN_SCK]) |-> pin_map[0] == FN_SCK;
  endproperty
  a_first_free: assert property (p_first_free) else $error("lowest pin not used");

  property p_skip_taken;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    skip_r[0] |-> pin_map[0] == FN_NONE;
  endproperty
  a_skip_taken: assert property (p_skip_taken) else $error("skipped pin assigned");

  property p_fixed_uart;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    fn_en[FN_TX] |-> pin_map[TX_PIN] == FN_TX && pin_map[RX_PIN] == FN_RX;
  endproperty
  a_fixed_uart: assert property (p_fixed_uart) else $error("serial pins moved");

endmodule

// [pxb_pkg.sv]
// Constants, register map and carrier types of the port crossbar block.
// Assumes a 32-bit AXI4-Lite register bus and a 24-pin port of three bytes.
package pxb_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NPINS  = 24;
  localparam int NFUNC  = 17;
  localparam int ADDR_W = 8;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_IN_MODE   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OUT_MODE  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SKIP      = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RSEL0     = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_RSEL1     = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_LATCH     = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PIN_STATE = 8'h18;

  // ----------------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------------
  localparam logic [NPINS-1:0] IN_MODE_RST  = 24'hffffff;
  localparam logic [NPINS-1:0] OUT_MODE_RST = 24'h000000;
  localparam logic [NPINS-1:0] SKIP_RST     = 24'h000000;
  localparam logic [NPINS-1:0] LATCH_RST    = 24'hffffff;
  localparam logic [7:0]       RSEL0_RST    = 8'h00;
  localparam logic [7:0]       RSEL1_RST    = 8'h00;
  localparam logic [7:0]       RSEL0_MASK   = 8'h3f;
  localparam logic [7:0]       RSEL1_MASK   = 8'hfb;

  // ----------------------------------------------------------------------
  // Field positions of the route select registers
  // ----------------------------------------------------------------------
  localparam int R0_UART    = 0;
  localparam int R0_SPI     = 1;
  localparam int R0_SMB     = 2;
  localparam int R0_SYSCK   = 3;
  localparam int R0_CMP     = 4;
  localparam int R0_CMPA    = 5;
  localparam int R1_PCA_LO  = 0;
  localparam int R1_CNTIN   = 3;
  localparam int R1_TMR0    = 4;
  localparam int R1_TMR1    = 5;
  localparam int R1_XBAR    = 6;
  localparam int R1_WPUD    = 7;

  // ----------------------------------------------------------------------
  // Function indices, in crossbar priority order
  // ----------------------------------------------------------------------
  localparam logic [4:0] FN_TX   = 5'h00;
  localparam logic [4:0] FN_RX   = 5'h01;
  localparam logic [4:0] FN_SCK  = 5'h02;
  localparam logic [4:0] FN_MISO = 5'h03;
  localparam logic [4:0] FN_MOSI = 5'h04;
  localparam logic [4:0] FN_NSS  = 5'h05;
  localparam logic [4:0] FN_SDA  = 5'h06;
  localparam logic [4:0] FN_SCL  = 5'h07;
  localparam logic [4:0] FN_CMP  = 5'h08;
  localparam logic [4:0] FN_CMPA = 5'h09;
  localparam logic [4:0] FN_SYSC = 5'h0a;
  localparam logic [4:0] FN_CEX0 = 5'h0b;
  localparam logic [4:0] FN_CEX1 = 5'h0c;
  localparam logic [4:0] FN_CEX2 = 5'h0d;
  localparam logic [4:0] FN_CNT  = 5'h0e;
  localparam logic [4:0] FN_TMR0 = 5'h0f;
  localparam logic [4:0] FN_TMR1 = 5'h10;
  localparam logic [4:0] FN_NONE = 5'h1f;
  localparam int         TX_PIN  = 4;
  localparam int         RX_PIN  = 5;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef logic [NPINS-1:0][4:0] pxb_map_t;

  typedef struct packed {
    logic [NFUNC-1:0] val;
    logic [NFUNC-1:0] drv;
  } pxb_periph_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } pxb_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pxb_axi_rsp_t;

endpackage

// [pxb_pin_cell.sv]
// One port pin: driver mode, output enable and weak pullup, registered.
// Assumes the crossbar core supplies the pin's routed value and drive request.
`timescale 1ns/1ps
module pxb_pin_cell (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_b_i,
  // Configuration
  input  wire logic digital_i,
  input  wire logic push_pull_i,
  input  wire logic force_od_i,
  input  wire logic xbar_en_i,
  input  wire logic wpu_dis_i,
  // Routed data
  input  wire logic val_i,
  input  wire logic drv_i,
  // Pad side
  output logic      pad_out_o,
  output logic      pad_oe_o,
  output logic      pad_pullup_o
);

  logic od;
  logic out_nxt;
  logic oe_nxt;
  logic pu_nxt;

  always_comb begin
    od      = ~push_pull_i | force_od_i;
    out_nxt = od ? 1'b0 : val_i;
    oe_nxt  = digital_i & xbar_en_i & drv_i & (od ? ~val_i : 1'b1);
    pu_nxt  = digital_i & od & ~wpu_dis_i & ~oe_nxt;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      pad_out_o    <= 1'b0;
      pad_oe_o     <= 1'b0;
      pad_pullup_o <= 1'b0;
    end else begin
      pad_out_o    <= out_nxt;
      pad_oe_o     <= oe_nxt;
      pad_pullup_o <= pu_nxt;
    end
  end

endmodule

// [pxb_periph_model.sv]
// Far-side model: on-chip peripherals and the board wiring of the pads.
// Assumes the bench chooses what each peripheral drives.
`timescale 1ns/1ps
module pxb_periph_model
  import pxb_pkg::*;
(
  // Clock
  input  wire logic             sys_clk_i,
  // Bench control
  input  wire pxb_periph_t      want_i,
  // Pad side and peripheral outputs
  input  wire logic [NPINS-1:0] pad_out_i,
  input  wire logic [NPINS-1:0] pad_oe_i,
  input  wire logic [NPINS-1:0] pad_pullup_i,
  output pxb_periph_t           periph_o,
  output logic [NPINS-1:0]      pad_in_o
);
  logic [NPINS-1:0] last_r;

  assign periph_o = want_i;
  // A floating pad shows a changing level, never the last one
  always_comb begin
    for (int p = 0; p < NPINS; p++) begin
      pad_in_o[p] = pad_oe_i[p] ? pad_out_i[p] : (pad_pullup_i[p] | ~last_r[p]);
    end
  end
  always_ff @(posedge sys_clk_i) begin
    last_r <= pad_in_o;
  end
endmodule

// [test_port_crossbar_pin_config.sv]
// Self-checking bench of the port crossbar over AXI4-Lite.
// Assumes the far-side model in pxb_periph_model.
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module test_port_crossbar_pin_config;
  import pxb_pkg::*;
  logic sys_clk_i = 0;
  logic rst_b_i = 0;
  pxb_axi_req_t req = '0;
  pxb_axi_rsp_t rsp;
  pxb_periph_t want = '0;
  pxb_periph_t per;
  logic [NFUNC-1:0] pin_seen;
  logic [NPINS-1:0] pin_lv, pout, poe, ppu;
  logic [31:0] d;
  logic [1:0] r;
  int errors = 0;
  int checks = 0;
  int cyc = 0;

  always #20 sys_clk_i = ~sys_clk_i;

  pxb_crossbar u_pxb_crossbar (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .axi_req_i(req), .axi_rsp_o(rsp), .periph_i(per), .spi_four_wire_i(1'b0),
    .periph_in_o(pin_seen), .pad_in_i(pin_lv), .pad_out_o(pout), .pad_oe_o(poe),
    .pad_pullup_o(ppu));
  pxb_periph_model u_pxb_periph_model (.sys_clk_i(sys_clk_i), .want_i(want),
    .pad_out_i(pout), .pad_oe_i(poe), .pad_pullup_i(ppu), .periph_o(per),
    .pad_in_o(pin_lv));

  task automatic print_verdict();
    if (errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    req.awvalid <= 1; req.awaddr <= a; req.wvalid <= 1; req.wdata <= v;
    req.wstrb <= 4'hf; req.bready <= 1;
    do begin
      @(posedge sys_clk_i);
      if (rsp.awready) req.awvalid <= 0;
      if (rsp.wready) req.wvalid <= 0;
    end while ((req.awvalid && !rsp.awready) || (req.wvalid && !rsp.wready));
    do @(posedge sys_clk_i); while (rsp.bvalid !== 1'b1);
    req.bready <= 0;
    @(posedge sys_clk_i);
  endtask

  task automatic rd(input logic [7:0] a);
    req.arvalid <= 1; req.araddr <= a; req.rready <= 1;
    do @(posedge sys_clk_i); while (rsp.arready !== 1'b1);
    req.arvalid <= 0;
    do @(posedge sys_clk_i); while (rsp.rvalid !== 1'b1);
    d = rsp.rdata; r = rsp.rresp;
    req.rready <= 0;
    @(posedge sys_clk_i);
  endtask

  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_b_i <= 1;
    @(posedge sys_clk_i);
    rd(OFS_IN_MODE); `CHK(d, 32'h00ffffff)
    `CHK(poe, 24'h000000)
    `CHK(ppu, 24'hffffff)
    rd(8'h1c); `CHK(r, RESP_SLVERR)
    // Modes, skips, routes, then enable
    wr(OFS_IN_MODE, 32'h00fffffe);
    wr(OFS_OUT_MODE, 32'h000000fe);
    wr(OFS_SKIP, 32'h00000001);
    wr(OFS_LATCH, 32'h00000000);
    wr(OFS_RSEL0, 32'h00000005);
    repeat (3) @(posedge sys_clk_i);
    `CHK(poe, 24'h000000)
    `CHK(ppu, 24'hffff00)
    rd(OFS_PIN_STATE); `CHK(d[0], 1'b0)
    `CHK(d[23:8], 16'hffff)
    want.drv[FN_TX] <= 1; want.drv[FN_SDA] <= 1; want.val[FN_SDA] <= 1;
    want.drv[FN_SCL] <= 1;
    wr(OFS_RSEL1, 32'h00000040);
    repeat (3) @(posedge sys_clk_i);
    `CHK(poe, 24'hffffdc)
    `CHK(pout, 24'h000000)
    `CHK(ppu, 24'h000002)
    `CHK(pin_seen[FN_SDA +: 2], 2'b01)
    wr(OFS_SKIP, 32'h00000003);
    repeat (3) @(posedge sys_clk_i);
    `CHK(poe, 24'hffffda)
    want.val[FN_TX] <= 1; want.val[FN_SCL] <= 1; want.val[FN_SDA] <= 0;
    repeat (3) @(posedge sys_clk_i);
    `CHK(poe, 24'hffffd6)
    `CHK(pout, 24'h000010)
    wr(OFS_RSEL1, 32'h000000c0);
    repeat (3) @(posedge sys_clk_i);
    `CHK(ppu, 24'h000000)
    wr(OFS_RSEL1, 32'h00000000);
    repeat (3) @(posedge sys_clk_i);
    `CHK(poe, 24'h000000)
    `CHK(pin_seen, 17'h1ffff)
    // Serial peripheral alone takes the three lowest pins
    wr(OFS_IN_MODE, 32'h00ffffff);
    wr(OFS_SKIP, 32'h00000000);
    wr(OFS_RSEL0, 32'h00000002);
    wr(OFS_RSEL1, 32'h00000040);
    repeat (3) @(posedge sys_clk_i);
    `CHK(poe, 24'hfffff8)
    print_verdict();
  end
endmodule
